// ---- sld_defines.svh ----
// bit positions, field layouts and timing counts for the synthesizer latch decoder
`ifndef SLD_DEFINES_SVH
`define SLD_DEFINES_SVH
`define SLD_WORD_W 24
`define SLD_ADDR_CTRL 2'b00
`define SLD_ADDR_FB 2'b10
`define SLD_ADDR_REF 2'b01
// control word fields
`define SLD_C_PRESC_LO 22
`define SLD_C_PD_GATE 21
`define SLD_C_PD_REQ 20
`define SLD_C_CUR2_LO 17
`define SLD_C_CUR1_LO 14
`define SLD_C_PWR_LO 12
`define SLD_C_MUTE 11
`define SLD_C_GAIN 10
`define SLD_C_TRI 9
`define SLD_C_POL 8
`define SLD_C_MUX_LO 5
`define SLD_C_CRST 4
`define SLD_C_CORE_LO 2
// feedback word fields
`define SLD_F_DSEL 23
`define SLD_F_DIV2 22
`define SLD_F_GAIN 21
`define SLD_F_MAIN_LO 8
`define SLD_F_SWAL_LO 2
// reference word fields
`define SLD_R_BSC_LO 20
`define SLD_R_TEST 19
`define SLD_R_PRECISION 18
`define SLD_R_ABP_LO 16
`define SLD_R_DIV_LO 2
// lock detect timing and divider minimums
`define SLD_LOCK_ERR_NS 15
`define SLD_CLK_PERIOD_NS 25
`define SLD_LOCK_ERR_CYC ((`SLD_LOCK_ERR_NS) / (`SLD_CLK_PERIOD_NS) < 1 ? 1 : \
  (`SLD_LOCK_ERR_NS) / (`SLD_CLK_PERIOD_NS))
`define SLD_LOCK_CNT_HI 3'h5
`define SLD_LOCK_CNT_LO 3'h3
`define SLD_MAIN_MIN 13'h0003
`define SLD_REF_MIN 14'h0001
`endif

// ---- sld_pkg.sv ----
// types shared by the synthesizer latch decoder
package sld_pkg;
  // decoded control word
  typedef struct packed {
    logic [1:0] prescaler_sel;
    logic powerdown_gating_bit;
    logic powerdown_request_bit;
    logic [2:0] pump_current_two;
    logic [2:0] pump_current_one;
    logic [1:0] output_power;
    logic mute_till_lock;
    logic pump_tristate;
    logic detector_polarity;
    logic [2:0] mux_select;
    logic counter_reset;
    logic [1:0] core_power;
  } sld_ctrl_t;
  // decoded feedback and reference fields
  typedef struct packed {
    logic div2_select;
    logic div2_enable;
    logic [12:0] main_count;
    logic [4:0] swallow_count;
  } sld_fb_t;
  typedef struct packed {
    logic [1:0] band_clk_div;
    logic factory_test_bit;
    logic lock_precision_bit;
    logic [1:0] antibacklash;
    logic [13:0] ref_divide;
  } sld_ref_t;
  // power-down sequencing; gray coded along the usual path
  typedef enum logic [1:0] {
    SLD_RUN = 2'b00,
    SLD_WAIT1 = 2'b01,
    SLD_WAIT2 = 2'b11,
    SLD_DOWN = 2'b10
  } sld_pd_state_t;
endpackage

// ---- sld_sync.sv ----
// two-flop synchroniser for pin inputs
`timescale 1ns/10ps
module sld_sync (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic d,
  output logic q
);
  // ----------------------------------------
  // the first stage is read only by the second
  // ----------------------------------------
  logic meta_reg;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      meta_reg <= 1'b0;
      q <= 1'b0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule // sld_sync

// ---- sld_latch_decoder.sv ----
// three-wire latch decoder with power-down, lock detect and counter control
`timescale 1ns/10ps
`include "sld_defines.svh"
// Notes on behaviour
// - address bits 00 control, 10 feedback, 01 reference
// - request with gating zero: power down at once
// - both set: down on second reference edge
// - chip enable low disables immediately
// - power-down loads counters, tri-states, resets lock
// - serial register keeps working in power-down
// - two three-bit pump current settings held
// - mute bit keeps outputs off until lock
// - gain bit follows last write, either word
// - tri-state bit floats the charge pump
// - polarity one positive, zero inverted
// - counter reset bit holds all counters
// - power, core and mux fields drive outputs
// - swallow 0..31, main 3..8191
// - total division is P times main plus swallow
// - feedback bit 22 enables output halving
// - feedback bit 23 picks prescaler input
// - reference divide 1..16383
// - reference bits 16-17 set antibacklash width
// - lock after five or three good cycles
// - test bit zero ignores test latch
// - band clock from reference output, optional divider
// - 24 bits shifted, transferred on load rising
module sld_latch_decoder
  import sld_pkg::*;
#(
  parameter int WORD_W = `SLD_WORD_W
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic serial_clk,
  input wire logic serial_data,
  input wire logic load_enable,
  input wire logic chip_enable,
  input wire logic ref_counter_out,
  input wire logic phase_error_pulse,
  input wire logic [7:0] test_latch,
  output logic powered_down,
  output logic counters_load,
  output logic pump_hiz,
  output logic rf_out_enable,
  output logic ref_buffer_enable,
  output logic lock_detect,
  output logic [2:0] pump_current,
  output logic detector_polarity,
  output logic [1:0] output_power,
  output logic [1:0] core_power,
  output logic [2:0] mux_select,
  output logic div2_enable,
  output logic div2_select,
  output logic [17:0] feedback_division,
  output logic [13:0] ref_divide,
  output logic [1:0] antibacklash,
  output logic band_select_clk,
  output logic [7:0] test_mode_out
);
  // ----------------------------------------
  // elaboration checks
  // ----------------------------------------
  if (WORD_W != 24) begin : g_bad_width
    $error("latch words are 24 bits wide");
  end

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic sclk_s, sdata_s, load_s, ce_s, refo_s, perr_s; // synchronised pins
  sld_sync u_s0 (.mclk(mclk), .sys_rst(sys_rst), .d(serial_clk), .q(sclk_s));
  sld_sync u_s1 (.mclk(mclk), .sys_rst(sys_rst), .d(serial_data), .q(sdata_s));
  sld_sync u_s2 (.mclk(mclk), .sys_rst(sys_rst), .d(load_enable), .q(load_s));
  sld_sync u_s3 (.mclk(mclk), .sys_rst(sys_rst), .d(chip_enable), .q(ce_s));
  sld_sync u_s4 (.mclk(mclk), .sys_rst(sys_rst), .d(ref_counter_out), .q(refo_s));
  sld_sync u_s5 (.mclk(mclk), .sys_rst(sys_rst), .d(phase_error_pulse), .q(perr_s));

  // ----------------------------------------
  // edge detection
  // ----------------------------------------
  logic sclk_d_reg, load_d_reg, refo_d_reg; // delayed copies
  logic sclk_rise, load_rise, refo_rise; // one-cycle edges
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sclk_d_reg <= 1'b0;
      load_d_reg <= 1'b0;
      refo_d_reg <= 1'b0;
    end else begin
      sclk_d_reg <= sclk_s;
      load_d_reg <= load_s;
      refo_d_reg <= refo_s;
    end
  end
  assign sclk_rise = sclk_s & ~sclk_d_reg;
  assign load_rise = load_s & ~load_d_reg;
  assign refo_rise = refo_s & ~refo_d_reg;

  // ----------------------------------------
  // serial shift register
  // ----------------------------------------
  // keeps shifting in power-down; the host owns the word framing
  logic [WORD_W-1:0] shift_reg; // msb first
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      shift_reg <= '0;
    end else if (sclk_rise) begin
      shift_reg <= {shift_reg[WORD_W-2:0], sdata_s};
    end
  end

  // ----------------------------------------
  // latched words
  // ----------------------------------------
  logic [WORD_W-1:0] general_control_word_reg; // write-only words
  logic [WORD_W-1:0] feedback_divider_word_reg;
  logic [WORD_W-1:0] reference_divider_word_reg;
  logic wr_ctrl, wr_fb, wr_ref; // one-cycle commit strobes
  assign wr_ctrl = load_rise && shift_reg[1:0] == `SLD_ADDR_CTRL;
  assign wr_fb = load_rise && shift_reg[1:0] == `SLD_ADDR_FB;
  assign wr_ref = load_rise && shift_reg[1:0] == `SLD_ADDR_REF;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      general_control_word_reg <= '0;
      feedback_divider_word_reg <= '0;
      reference_divider_word_reg <= '0;
    end else begin
      // words hold until a commit, even in power-down
      if (wr_ctrl) general_control_word_reg <= shift_reg;
      if (wr_fb) feedback_divider_word_reg <= shift_reg;
      if (wr_ref) reference_divider_word_reg <= shift_reg;
    end
  end

  // ----------------------------------------
  // field views
  // ----------------------------------------
  sld_ctrl_t ctl; // control fields
  sld_fb_t fb; // feedback fields
  sld_ref_t rf; // reference fields
  // the gain bit is skipped here: it lives in the shared gain flop below
  assign ctl = {general_control_word_reg[WORD_W-1:`SLD_C_MUTE],
                general_control_word_reg[`SLD_C_TRI:`SLD_C_CORE_LO]};
  assign fb = {feedback_divider_word_reg[`SLD_F_DSEL], feedback_divider_word_reg[`SLD_F_DIV2],
               feedback_divider_word_reg[`SLD_F_MAIN_LO +: 13],
               feedback_divider_word_reg[`SLD_F_SWAL_LO +: 5]};
  assign rf = reference_divider_word_reg[WORD_W-3:2];

  // ----------------------------------------
  // pump gain: one element, last writer wins
  // ----------------------------------------
  logic gain_reg; // shared gain bit
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      gain_reg <= 1'b0;
    end else if (wr_ctrl) begin
      gain_reg <= shift_reg[`SLD_C_GAIN];
    end else if (wr_fb) begin
      gain_reg <= shift_reg[`SLD_F_GAIN];
    end
  end

  // ----------------------------------------
  // power-down sequencer
  // ----------------------------------------
  sld_pd_state_t pd_reg; // software power-down state
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pd_reg <= SLD_RUN;
    end else if (wr_ctrl) begin
      // a new control word restarts the sequence
      if (!shift_reg[`SLD_C_PD_REQ]) pd_reg <= SLD_RUN;
      else if (!shift_reg[`SLD_C_PD_GATE]) pd_reg <= SLD_DOWN;
      else pd_reg <= SLD_WAIT1;
    end else begin
      case (pd_reg)
        SLD_WAIT1: if (refo_rise) pd_reg <= SLD_WAIT2;
        SLD_WAIT2: if (refo_rise) pd_reg <= SLD_DOWN;
        SLD_DOWN: pd_reg <= SLD_DOWN;
        SLD_RUN: pd_reg <= SLD_RUN;
        default: pd_reg <= SLD_RUN;
      endcase
    end
  end
  logic pd_now; // combined power-down
  assign pd_now = (pd_reg == SLD_DOWN) | ~ce_s;

  // ----------------------------------------
  // lock detect
  // ----------------------------------------
  // phase error pulse wider than the window breaks the run
  logic [3:0] err_len_reg; // current error pulse length in cycles
  logic [2:0] good_cnt_reg; // consecutive good reference cycles
  logic bad_cycle_reg; // error seen in this reference cycle
  logic lock_reg; // lock state
  logic [2:0] need; // cycles needed for lock
  assign need = rf.lock_precision_bit ? `SLD_LOCK_CNT_HI : `SLD_LOCK_CNT_LO;
  always_ff @(posedge mclk) begin
    if (sys_rst || pd_now) begin
      err_len_reg <= 4'h0;
      good_cnt_reg <= 3'h0;
      bad_cycle_reg <= 1'b0;
      lock_reg <= 1'b0;
    end else begin
      err_len_reg <= perr_s ? err_len_reg + 4'h1 : 4'h0;
      if (refo_rise) begin
        bad_cycle_reg <= 1'b0;
        if (bad_cycle_reg) begin
          good_cnt_reg <= 3'h0;
          lock_reg <= 1'b0;
        end else if (good_cnt_reg + 3'h1 >= need) begin
          lock_reg <= 1'b1;
          good_cnt_reg <= need;
        end else begin
          good_cnt_reg <= good_cnt_reg + 3'h1;
        end
      end
      // set after the clear, so an error on a reference edge is not lost
      if (perr_s && err_len_reg >= 4'(`SLD_LOCK_ERR_CYC)) bad_cycle_reg <= 1'b1;
    end
  end

  // ----------------------------------------
  // band-select clock divider
  // ----------------------------------------
  // divider code 0 passes the reference output through
  logic [3:0] bs_cnt_reg; // divider count
  logic bs_clk_reg; // divided clock
  always_ff @(posedge mclk) begin
    if (sys_rst || pd_now) begin
      bs_cnt_reg <= 4'h0;
      bs_clk_reg <= 1'b0;
    end else if (rf.band_clk_div == 2'b00) begin
      bs_clk_reg <= refo_s;
    end else if (refo_rise) begin
      if (bs_cnt_reg >= ({2'b00, rf.band_clk_div} << 1) - 4'h1) begin
        bs_cnt_reg <= 4'h0;
        bs_clk_reg <= ~bs_clk_reg;
      end else begin
        bs_cnt_reg <= bs_cnt_reg + 4'h1;
      end
    end
  end

  // ----------------------------------------
  // output registers
  // ----------------------------------------
  logic [4:0] presc_mod; // prescaler modulus 8, 16 or 32
  logic [12:0] main_eff; // clamped main count
  logic [13:0] ref_eff; // clamped reference ratio
  always_comb begin
    case (ctl.prescaler_sel)
      2'b00: presc_mod = 5'h08;
      2'b01: presc_mod = 5'h10;
      default: presc_mod = 5'h00; // 32 encoded as shift below
    endcase
    main_eff = fb.main_count < `SLD_MAIN_MIN ? `SLD_MAIN_MIN : fb.main_count;
    ref_eff = rf.ref_divide < `SLD_REF_MIN ? `SLD_REF_MIN : rf.ref_divide;
  end
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      powered_down <= 1'b1;
      counters_load <= 1'b1;
      pump_hiz <= 1'b1;
      rf_out_enable <= 1'b0;
      ref_buffer_enable <= 1'b0;
      lock_detect <= 1'b0;
      pump_current <= 3'h0;
      detector_polarity <= 1'b0;
      output_power <= 2'h0;
      core_power <= 2'h0;
      mux_select <= 3'h0;
      div2_enable <= 1'b0;
      div2_select <= 1'b0;
      feedback_division <= 18'h00000;
      ref_divide <= 14'h0001;
      antibacklash <= 2'h0;
      band_select_clk <= 1'b0;
      test_mode_out <= 8'h00;
    end else begin
      powered_down <= pd_now;
      counters_load <= pd_now | ctl.counter_reset;
      pump_hiz <= pd_now | ctl.pump_tristate;
      rf_out_enable <= ~pd_now & (~ctl.mute_till_lock | lock_reg);
      ref_buffer_enable <= ~pd_now;
      lock_detect <= lock_reg;
      pump_current <= gain_reg ? ctl.pump_current_two : ctl.pump_current_one;
      detector_polarity <= ctl.detector_polarity;
      output_power <= ctl.output_power;
      core_power <= ctl.core_power;
      mux_select <= ctl.mux_select;
      div2_enable <= fb.div2_enable;
      div2_select <= fb.div2_select;
      // modulus times main plus swallow
      feedback_division <= (presc_mod == 5'h00 ? {main_eff, 5'h00}
                            : 18'(main_eff) * 18'(presc_mod)) + 18'(fb.swallow_count);
      ref_divide <= ref_eff;
      antibacklash <= rf.antibacklash;
      band_select_clk <= bs_clk_reg;
      test_mode_out <= rf.factory_test_bit ? test_latch : 8'h00;
    end
  end
endmodule // sld_latch_decoder

// ---- sld_latch_decoder_properties.sv ----
// port-level checks for the synthesizer latch decoder
`timescale 1ns/10ps
module sld_latch_decoder_properties (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic load_enable,
  input wire logic chip_enable,
  input wire logic powered_down,
  input wire logic counters_load,
  input wire logic pump_hiz,
  input wire logic rf_out_enable,
  input wire logic ref_buffer_enable,
  input wire logic lock_detect,
  input wire logic [17:0] feedback_division,
  input wire logic [13:0] ref_divide,
  input wire logic [1:0] antibacklash
);
  // ----------------------------------------
  // helper: cycles since load enable was high
  // ----------------------------------------
  logic [3:0] quiet_reg; // saturates so long idle spans stay cheap
  always_ff @(posedge mclk) begin
    if (sys_rst || load_enable) begin
      quiet_reg <= 4'h0;
    end else if (quiet_reg != 4'hf) begin
      quiet_reg <= quiet_reg + 4'h1;
    end
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  // two-cycle antecedents allow outputs registered one stage after the state
  a_pd_counters: assert property (powered_down [*2] |-> counters_load)
    else $error("counters not loaded in power-down");
  a_pd_pump: assert property (powered_down [*2] |-> pump_hiz)
    else $error("pump driving in power-down");
  a_pd_outputs: assert property (powered_down [*2] |-> !rf_out_enable && !lock_detect)
    else $error("outputs or lock active in power-down");
  a_pd_buffer: assert property (powered_down [*2] |-> !ref_buffer_enable)
    else $error("reference buffer on in power-down");
  a_buffer_back: assert property ($fell(powered_down) |-> ##[0:2] ref_buffer_enable)
    else $error("reference buffer not restored");
  a_ce_disable: assert property (!chip_enable [*4] |-> ##[0:1] powered_down)
    else $error("chip enable low did not disable");
  a_ref_floor: assert property (ref_divide != 14'h0)
    else $error("reference divide below one");
  a_fb_floor: assert property ($changed(feedback_division) |-> feedback_division >= 18'h18)
    else $error("feedback division below minimum");
  a_words_hold: assert property (quiet_reg == 4'hf |-> $stable(ref_divide) &&
    $stable(feedback_division) && $stable(antibacklash))
    else $error("word output changed without load");
  c_pd: cover property ($rose(powered_down));
  c_lock: cover property ($rose(lock_detect));
  c_ce: cover property (!chip_enable [*4]);
endmodule // sld_latch_decoder_properties

bind sld_latch_decoder sld_latch_decoder_properties sld_latch_decoder_properties_i (
  .mclk, .sys_rst, .load_enable, .chip_enable, .powered_down, .counters_load, .pump_hiz,
  .rf_out_enable, .ref_buffer_enable, .lock_detect, .feedback_division, .ref_divide,
  .antibacklash
);

// ---- sld_host_model.sv ----
// host model shifting 24-bit words over the three-wire link
`timescale 1ns/10ps
module sld_host_model (
  input wire logic mclk,
  output logic serial_clk,
  output logic serial_data,
  output logic load_enable
);
  // clock and load idle low between frames
  initial begin
    serial_clk = 1'b0;
    serial_data = 1'b0;
    load_enable = 1'b0;
  end
  // each pin phase spans three cycles, above the two-cycle minimum
  task automatic hold3;
    repeat (3) @(negedge mclk);
  endtask
  // msb first; caller picks the address bits
  task automatic send(input logic [23:0] w);
    for (int i = 23; i >= 0; i--) begin
      serial_data = w[i];
      hold3;
      serial_clk = 1'b1;
      hold3;
      serial_clk = 1'b0;
    end
    serial_data = ~w[0]; // released line must not show a stale bit
    load_enable = 1'b1;
    hold3;
    load_enable = 1'b0;
    hold3;
  endtask
endmodule // sld_host_model

// ---- sld_latch_decoder_test.sv ----
// self-checking bench for the synthesizer latch decoder
`timescale 1ns/10ps
module sld_latch_decoder_test;
  logic mclk, sys_rst, chip_enable, ref_counter_out, phase_error_pulse;
  logic serial_clk, serial_data, load_enable, powered_down, counters_load, pump_hiz;
  logic rf_out_enable, ref_buffer_enable, lock_detect, detector_polarity;
  logic div2_enable, div2_select, band_select_clk;
  logic [7:0] test_latch, test_mode_out;
  logic [2:0] pump_current, mux_select;
  logic [1:0] output_power, core_power, antibacklash;
  logic [17:0] feedback_division;
  logic [13:0] ref_divide;
  int errors, n_compared;
  sld_latch_decoder sld_latch_decoder_i (.mclk, .sys_rst, .serial_clk, .serial_data,
    .load_enable, .chip_enable, .ref_counter_out, .phase_error_pulse, .test_latch,
    .powered_down, .counters_load, .pump_hiz, .rf_out_enable, .ref_buffer_enable,
    .lock_detect, .pump_current, .detector_polarity, .output_power, .core_power,
    .mux_select, .div2_enable, .div2_select, .feedback_division, .ref_divide,
    .antibacklash, .band_select_clk, .test_mode_out);
  sld_host_model sld_host_model_i (.mclk, .serial_clk, .serial_data, .load_enable);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input logic [17:0] got, input logic [17:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // outputs settle within six cycles of the load rise
  task automatic wr(input logic [23:0] w);
    sld_host_model_i.send(w);
    idle(8);
  endtask
  task automatic ref_pulse(input int n);
    repeat (n) begin
      ref_counter_out = 1'b1;
      idle(4);
      ref_counter_out = 1'b0;
      idle(4);
    end
  endtask
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_program;
    wr(24'h020015);
    wr(24'h4ab168);
    wr(24'h40641e);
    check(ref_divide, 18'h5);
    check(antibacklash, 18'h2);
    check(pump_current, 18'h2);
    check(detector_polarity, 18'h1);
    check(output_power, 18'h3);
    check(core_power, 18'h2);
    check(mux_select, 18'h3);
    check(feedback_division, 18'h647);
    check(div2_enable, 18'h1);
    check(test_mode_out, 18'h0);
    check(rf_out_enable, 18'h1);
    check(ref_buffer_enable, 18'h1);
    $display("t_program finished");
  endtask
  // gain written from the feedback word, then from each prescaler control word
  task automatic t_gain;
    wr(24'ha0027e);
    check(pump_current, 18'h5);
    check(div2_select, 18'h1);
    check(div2_enable, 18'h0);
    for (int p = 0; p < 4; p++) begin
      wr(24'h0ab168 | (24'(p) << 22));
      check(feedback_division, 18'(((p == 0) ? 8 : (p == 1) ? 16 : 32) * 3 + 31));
      check(pump_current, 18'h2);
    end
    $display("t_gain finished");
  endtask
  task automatic t_ref;
    wr(24'h04fffd);
    check(ref_divide, 18'h3fff);
    check(antibacklash, 18'h0);
    wr(24'hffffff);
    check(ref_divide, 18'h3fff);
    wr(24'h000025);
    check(ref_divide, 18'h9);
    $display("t_ref finished");
  endtask
  task automatic t_powerdown;
    wr(24'h5ab168);
    check(powered_down, 18'h1);
    check(ref_buffer_enable, 18'h0);
    check(pump_hiz, 18'h1);
    wr(24'h000011);
    check(ref_divide, 18'h4);
    wr(24'h7ab168);
    idle(10);
    check(powered_down, 18'h0);
    wr(24'h4ab168);
    check(powered_down, 18'h0);
    wr(24'h7ab168);
    ref_pulse(1);
    check(powered_down, 18'h0);
    ref_pulse(1);
    check(powered_down, 18'h1);
    wr(24'h4ab168);
    $display("t_powerdown finished");
  endtask
  task automatic t_ctrl_bits;
    wr(24'h4ab378);
    check(counters_load, 18'h1);
    check(pump_hiz, 18'h1);
    check(powered_down, 18'h0);
    wr(24'h4ab168);
    check(counters_load, 18'h0);
    check(pump_hiz, 18'h0);
    $display("t_ctrl_bits finished");
  endtask
  task automatic t_lock;
    wr(24'h4ab968);
    check(rf_out_enable, 18'h0);
    ref_pulse(2);
    check(lock_detect, 18'h0);
    ref_pulse(3);
    check(lock_detect, 18'h1);
    check(rf_out_enable, 18'h1);
    chip_enable = 1'b0;
    idle(5);
    check(powered_down, 18'h1);
    check(lock_detect, 18'h0);
    chip_enable = 1'b1;
    idle(5);
    check(powered_down, 18'h0);
    $display("t_lock finished");
  endtask
  // band clock passes the reference, then divides by four; test bit; five-cycle lock
  task automatic t_band;
    ref_counter_out = 1'b1;
    idle(6);
    check(band_select_clk, 18'h1);
    ref_counter_out = 1'b0;
    idle(6);
    check(band_select_clk, 18'h0);
    wr(24'h100025);
    ref_pulse(1);
    check(band_select_clk, 18'h0);
    ref_pulse(1);
    check(band_select_clk, 18'h1);
    wr(24'h180025);
    check(test_mode_out, 18'ha5);
    wr(24'h140025);
    phase_error_pulse = 1'b1;
    idle(3);
    phase_error_pulse = 1'b0;
    idle(3);
    ref_pulse(1);
    check(lock_detect, 18'h0);
    ref_pulse(4);
    check(lock_detect, 18'h0);
    ref_pulse(1);
    check(lock_detect, 18'h1);
    $display("t_band finished");
  endtask
  // ----------------------------------------
  // clock, watchdog and main sequence
  // ----------------------------------------
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  initial begin
    repeat (40000) @(posedge mclk);
    errors++;
    wrap_up;
  end
  initial begin
    errors = 0;
    n_compared = 0;
    sys_rst = 1'b1;
    chip_enable = 1'b1;
    ref_counter_out = 1'b0;
    phase_error_pulse = 1'b0;
    test_latch = 8'ha5;
    idle(8);
    sys_rst = 1'b0;
    idle(2);
    t_program;
    t_gain;
    t_ref;
    t_powerdown;
    t_ctrl_bits;
    t_lock;
    t_band;
    wrap_up;
  end
endmodule // sld_latch_decoder_test
